// [core/pbw_pkg.sv]
// constants and types of the peripheral bus wait-state configuration block
// Function
// - low wait register: sixteen 2-bit fields, slave n at bits 2n+1:2n
// - field value 00 gives the basic two-cycle peripheral transfer, the reset value of all fields but slaves 04, 05, 0A, 0B, 2A, 2B
// - values 01, 10, 11 add one, two, three wait cycles
// - mid wait register sits at offset 0x04 and resets to zero
// - mid wait register holds slaves 10 to 1F, slave 1F at bits 31:30
// - wait registers at 0x00, 0x04, 0x08 from base 0xFFFE_0000, 32-bit read/write
// - low wait register resets to 0x0050_0500
package pbw_pkg;
    localparam logic [31:0] PBW_BASE_ADDR = 32'hfffe_0000;
    localparam int PBW_ADDR_BITS = 12;
    localparam logic [11:0] PBW_OFF_LOW = 12'h000;
    localparam logic [11:0] PBW_OFF_MID = 12'h004;
    localparam logic [11:0] PBW_OFF_HIGH = 12'h008;
    localparam logic [11:0] PBW_OFF_STATUS = 12'h00c;
    localparam logic [31:0] PBW_RST_LOW = 32'h0050_0500;
    localparam logic [31:0] PBW_RST_MID = 32'h0000_0000;
    localparam logic [31:0] PBW_RST_HIGH = 32'h0050_0000;
    localparam int PBW_FIELD_W = 2;
    localparam int PBW_FIELDS_PER_REG = 16;
    localparam int PBW_IDX_W = 6;
    localparam int PBW_BASE_CYCLES = 2;
    localparam int PBW_STAT_BUSY = 0;
    localparam int PBW_STAT_IDX_LSB = 8;
    localparam int PBW_STAT_WAIT_LSB = 16;
    localparam logic [1:0] PBW_HTRANS_NONSEQ_BIT = 2'h2;

    typedef enum logic [2:0] {
        PBW_REG_LOW,
        PBW_REG_MID,
        PBW_REG_HIGH,
        PBW_REG_STATUS,
        PBW_REG_NONE
    } pbw_reg_t;

    typedef enum logic [1:0] {
        PBW_ST_IDLE,
        PBW_ST_SETUP,
        PBW_ST_ACCESS
    } pbw_seq_st_t;
endpackage

// [core/pbw_wait_cnt.sv]
// down counter of the added wait cycles of one peripheral access
module pbw_wait_cnt
    import pbw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [PBW_FIELD_W-1:0] load_val,
    input wire logic step,
    output logic [PBW_FIELD_W-1:0] remaining
);
    typedef struct packed {
        logic [PBW_FIELD_W-1:0] cnt;
    } pbw_cnt_state_t;

    pbw_cnt_state_t cur;
    pbw_cnt_state_t next_cur;

    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.cnt = load_val;
        end else if (step && cur.cnt != '0) begin
            next_cur.cnt = cur.cnt - PBW_FIELD_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '0;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign remaining = cur.cnt;
endmodule

// [core/pbw_bridge.sv]
// wait-state registers and access sequencer of the peripheral bus bridge
module pbw_bridge
    import pbw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic acc_req,
    input wire logic [PBW_IDX_W-1:0] acc_slave_idx,
    output logic per_sel,
    output logic per_enable,
    output logic acc_done,
    output logic [PBW_IDX_W-1:0] per_slave_idx
);
    typedef struct packed {
        logic [31:0] wait_low;
        logic [31:0] wait_mid;
        logic [31:0] wait_high;
        logic wr_pend;
        pbw_reg_t wr_reg;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        pbw_seq_st_t st;
        logic [PBW_IDX_W-1:0] idx;
        logic [PBW_FIELD_W-1:0] wait_sel;
        logic sel;
        logic enable;
        logic done;
    } pbw_state_t;

    pbw_state_t cur;
    pbw_state_t next_cur;
    logic [PBW_FIELD_W-1:0] remaining;
    logic cnt_load;
    logic cnt_step;
    logic [PBW_FIELD_W-1:0] req_wait;
    logic addr_phase;
    pbw_reg_t addr_reg;

    // word offset to register; only haddr bits 11:0 are decoded, upper address bits are ignored
    function automatic pbw_reg_t reg_decode(input logic [31:0] a);
        logic [11:0] off;
        off = a[PBW_ADDR_BITS-1:0];
        case (off)
            PBW_OFF_LOW: reg_decode = PBW_REG_LOW;
            PBW_OFF_MID: reg_decode = PBW_REG_MID;
            PBW_OFF_HIGH: reg_decode = PBW_REG_HIGH;
            PBW_OFF_STATUS: reg_decode = PBW_REG_STATUS;
            default: reg_decode = PBW_REG_NONE;
        endcase
    endfunction

    // slave index to its 2-bit field: idx[5:4] picks the register, idx[3:0] the pair
    function automatic logic [PBW_FIELD_W-1:0] field_pick(
        input logic [31:0] r_low,
        input logic [31:0] r_mid,
        input logic [31:0] r_high,
        input logic [PBW_IDX_W-1:0] idx
    );
        logic [31:0] word;
        logic [4:0] lsb;
        word = '0;
        lsb = {idx[3:0], 1'b0};
        case (idx[5:4])
            2'h0: word = r_low;
            2'h1: word = r_mid;
            2'h2: word = r_high;
            default: word = '0;
        endcase
        field_pick = word[lsb +: PBW_FIELD_W];
    endfunction

    function automatic logic [31:0] status_word(input pbw_state_t s);
        logic [31:0] w;
        w = '0;
        w[PBW_STAT_BUSY] = s.sel;
        w[PBW_STAT_IDX_LSB +: PBW_IDX_W] = s.idx;
        w[PBW_STAT_WAIT_LSB +: PBW_FIELD_W] = s.wait_sel;
        status_word = w;
    endfunction

    assign addr_phase = hsel && hready && ((htrans & PBW_HTRANS_NONSEQ_BIT) != 2'h0);
    assign addr_reg = reg_decode(haddr);
    assign req_wait = field_pick(cur.wait_low, cur.wait_mid, cur.wait_high, acc_slave_idx);
    assign cnt_load = (cur.st == PBW_ST_IDLE) && acc_req;
    assign cnt_step = (cur.st == PBW_ST_ACCESS);

    pbw_wait_cnt u_wait_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .load(cnt_load),
        .load_val(req_wait),
        .step(cnt_step),
        .remaining(remaining)
    );

    always_comb begin
        logic [31:0] lo;
        logic [31:0] mi;
        logic [31:0] hi;
        next_cur = cur;
        lo = cur.wait_low;
        mi = cur.wait_mid;
        hi = cur.wait_high;

        // data phase of a write: the slave never stretches, so hwdata is final now
        if (cur.wr_pend) begin
            case (cur.wr_reg)
                PBW_REG_LOW: lo = hwdata;
                PBW_REG_MID: mi = hwdata;
                PBW_REG_HIGH: hi = hwdata;
                default: ;
            endcase
        end
        next_cur.wait_low = lo;
        next_cur.wait_mid = mi;
        next_cur.wait_high = hi;

        next_cur.wr_pend = 1'b0;
        next_cur.wr_reg = PBW_REG_NONE;
        next_cur.ready = 1'b1;
        next_cur.resp = 1'b0;
        if (addr_phase) begin
            if (hwrite) begin
                next_cur.wr_pend = 1'b1;
                next_cur.wr_reg = addr_reg;
            end else begin
                // read data built from the values after any write now finishing
                case (addr_reg)
                    PBW_REG_LOW: next_cur.rdata = lo;
                    PBW_REG_MID: next_cur.rdata = mi;
                    PBW_REG_HIGH: next_cur.rdata = hi;
                    PBW_REG_STATUS: next_cur.rdata = status_word(cur);
                    default: next_cur.rdata = '0;
                endcase
            end
        end

        next_cur.done = 1'b0;
        case (cur.st)
            PBW_ST_IDLE: begin
                // requests while busy are dropped; caller waits for acc_done
                if (acc_req) begin
                    next_cur.idx = acc_slave_idx;
                    next_cur.wait_sel = req_wait;
                    next_cur.sel = 1'b1;
                    next_cur.st = PBW_ST_SETUP;
                end
            end
            PBW_ST_SETUP: begin
                next_cur.enable = 1'b1;
                next_cur.st = PBW_ST_ACCESS;
                if (remaining == '0) begin
                    next_cur.done = 1'b1;
                end
            end
            PBW_ST_ACCESS: begin
                if (remaining == '0) begin
                    next_cur.sel = 1'b0;
                    next_cur.enable = 1'b0;
                    next_cur.st = PBW_ST_IDLE;
                end else if (remaining == PBW_FIELD_W'(1)) begin
                    next_cur.done = 1'b1;
                end
            end
            default: begin
                next_cur.sel = 1'b0;
                next_cur.enable = 1'b0;
                next_cur.st = PBW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '0;
            cur.wait_low <= PBW_RST_LOW;
            cur.wait_mid <= PBW_RST_MID;
            cur.wait_high <= PBW_RST_HIGH;
            cur.wr_reg <= PBW_REG_NONE;
            cur.ready <= 1'b1;
            cur.st <= PBW_ST_IDLE;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign hreadyout = cur.ready;
    assign hrdata = cur.rdata;
    assign hresp = cur.resp;
    assign per_sel = cur.sel;
    assign per_enable = cur.enable;
    assign acc_done = cur.done;
    assign per_slave_idx = cur.idx;
endmodule

// [tb/pbw_asserts.sv]
// assertions on the wait-state bridge ports
module pbw_asserts
    import pbw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic acc_req,
    input wire logic [PBW_IDX_W-1:0] acc_slave_idx,
    input wire logic per_sel,
    input wire logic per_enable,
    input wire logic acc_done,
    input wire logic [PBW_IDX_W-1:0] per_slave_idx
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ok; hreadyout && !hresp; endproperty
    a_ok: assert property (p_ok) else $error("bus not ready");
    property p_go; acc_req && !per_sel |=> per_sel ##1 per_enable; endproperty
    a_go: assert property (p_go) else $error("no access start");
    property p_first; $rose(per_sel) |-> !per_enable && !acc_done; endproperty
    a_first: assert property (p_first) else $error("setup cycle lost");
    property p_len; $rose(per_sel) |-> ##[1:4] acc_done; endproperty
    a_len: assert property (p_len) else $error("access too long");
    property p_end; acc_done |=> !per_sel && !per_enable && !acc_done; endproperty
    a_end: assert property (p_end) else $error("access not ended");
    property p_en; per_enable |-> per_sel; endproperty
    a_en: assert property (p_en) else $error("enable alone");
    property p_idx; $rose(per_sel) |-> per_slave_idx == $past(acc_slave_idx); endproperty
    a_idx: assert property (p_idx) else $error("wrong slave index");
    // hrdata may move only after a read address phase
    property p_hold; !(htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind pbw_bridge pbw_asserts pbw_asserts_inst (.hclk(hclk), .hresetn(hresetn),
    .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .acc_req(acc_req), .acc_slave_idx(acc_slave_idx),
    .per_sel(per_sel), .per_enable(per_enable), .acc_done(acc_done),
    .per_slave_idx(per_slave_idx));

// [tb/pbw_per_model.sv]
// peripheral slave model measuring select length
module pbw_per_model (
    input wire logic hclk,
    input wire logic per_sel,
    input wire logic per_enable,
    output logic [3:0] len,
    output logic [3:0] en_len
);
    logic [3:0] cnt = 4'h0;
    logic [3:0] en_cnt = 4'h0;
    // enable counted only inside a select window, so an enable outside select is not counted
    always_ff @(posedge hclk) begin
        if (per_sel) begin
            cnt <= cnt + 4'h1;
            en_cnt <= en_cnt + {3'h0, per_enable};
        end else if (cnt != 4'h0) begin
            len <= cnt;
            en_len <= en_cnt;
            cnt <= 4'h0;
            en_cnt <= 4'h0;
        end
    end
endmodule

// [tb/peripheral_bus_wait_config_tb_top.sv]
// self-checking bench of the wait-state bridge
module peripheral_bus_wait_config_tb_top import pbw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic acc_req = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [PBW_IDX_W-1:0] idx = 6'h00;
    logic hreadyout, hresp, per_sel, per_enable, acc_done;
    logic [PBW_IDX_W-1:0] per_slave_idx;
    logic [31:0] hrdata, rd, lo, mi, hi;
    logic [31:0] s = 32'hb8c9eb37;
    logic [3:0] len, en_len;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    // clk_en, hsel and hsize tied: one bus slave, word accesses only
    pbw_bridge pbw_bridge_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .acc_req(acc_req), .acc_slave_idx(idx), .per_sel(per_sel),
        .per_enable(per_enable), .acc_done(acc_done), .per_slave_idx(per_slave_idx));
    pbw_per_model pbw_per_model_inst (.hclk(hclk), .per_sel(per_sel),
        .per_enable(per_enable), .len(len), .en_len(en_len));
    initial begin
        forever #10 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // indices above the third register carry no field: zero waits
    function automatic logic [31:0] exp_len(input logic [5:0] i);
        logic [31:0] r;
        case (i[5:4])
            2'h0: r = lo;
            2'h1: r = mi;
            2'h2: r = hi;
            default: r = 32'h0;
        endcase
        return 32'h2 + {30'h0, r[2*i[3:0] +: 2]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= PBW_BASE_ADDR | {20'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hwdata <= ~d;
    endtask
    task automatic acc(input logic [5:0] i);
        @(posedge hclk);
        acc_req <= 1'b1;
        idx <= i;
        @(posedge hclk);
        acc_req <= 1'b0;
        idx <= ~i;
        do @(posedge hclk) #1; while (per_sel !== 1'b0);
        @(posedge hclk) #1;
        chk({28'h0, len}, exp_len(i));
        chk({28'h0, en_len}, exp_len(i) - 32'h1);
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, PBW_OFF_LOW, 32'h0);
        chk(rd, 32'h0050_0500);
        ahb(1'b0, PBW_OFF_MID, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, PBW_OFF_HIGH, 32'h0);
        chk(rd, 32'h0050_0000);
        ahb(1'b1, 12'h010, 32'hffff_ffff);
        ahb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        lo = 32'h0050_0500;
        mi = 32'h0;
        hi = 32'h0050_0000;
        acc(6'h04);
        acc(6'h1f);
        acc(6'h2a);
        acc(6'h35);
        // idle status: busy clear, last index, its wait field
        ahb(1'b0, PBW_OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_3500);
        $display("reset test done");
        for (int n = 0; n < 10; n++) begin
            lo = (n == 0) ? 32'h0000_00e4 : rnd();
            mi = (n == 0) ? 32'hc000_0000 : rnd();
            hi = (n == 0) ? 32'h0000_0000 : rnd();
            ahb(1'b1, PBW_OFF_LOW, lo);
            ahb(1'b1, PBW_OFF_MID, mi);
            ahb(1'b1, PBW_OFF_HIGH, hi);
            ahb(1'b0, PBW_OFF_LOW, 32'h0);
            chk(rd, lo);
            ahb(1'b0, PBW_OFF_MID, 32'h0);
            chk(rd, mi);
            ahb(1'b0, PBW_OFF_HIGH, 32'h0);
            chk(rd, hi);
            for (int k = 0; k < 5; k++) begin
                rd = rnd();
                acc(n == 0 ? (k == 4 ? 6'h1f : 6'(k)) : rd[5:0]);
            end
        end
        $display("access test done");
        // reset in mid-run must bring the low and mid wait registers back
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, PBW_OFF_LOW, 32'h0);
        chk(rd, 32'h0050_0500);
        ahb(1'b0, PBW_OFF_MID, 32'h0);
        chk(rd, 32'h0);
        $display("second reset test done");
        stop_test();
    end
endmodule
